// File: shared/odcr_pkg.sv
// Purpose: shared constants and types for the on-demand clock request block
// Assumes: one 40 MHz system clock, plain register port with 8-bit byte addresses
// Notes: register offsets are byte addresses, one 32-bit word each
package odcr_pkg;
  localparam int CLK_MHZ = 40;
  localparam int NUM_SRC = 2;
  localparam int NUM_GEN = 4;
  localparam int NUM_CH = 4;
  localparam int SRC_W = 1;
  localparam int GEN_W = 2;
  localparam int CH_W = 2;
  localparam int DIV_W = 6;
  localparam int CNT_W = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // source timing, times in ns, counts rounded up to whole clock cycles
  localparam int SRC_STARTUP_NS = 1000;
  localparam int SRC_STARTUP_CYC = (SRC_STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int SRC_PERIOD_NS = 200;
  localparam int SRC_PERIOD_CYC = (SRC_PERIOD_NS * CLK_MHZ + 999) / 1000;
  // register map
  localparam logic [ADDR_W-1:0] SRC_CFG_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] GEN_CFG_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] CH_CFG_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h30;
  localparam int REG_STRIDE = 4;
  // field positions
  localparam int SRC_OD_BIT = 0;
  localparam int SRC_STBY_BIT = 1;
  localparam int GEN_EN_BIT = 0;
  localparam int GEN_SRC_LSB = 1;
  localparam int GEN_DIV_LSB = 8;
  localparam int CH_EN_BIT = 0;
  localparam int CH_GEN_LSB = 1;
  localparam int CH_UNMASK_BIT = 8;
  localparam int STAT_RUN_LSB = 0;
  localparam int STAT_RDY_LSB = 4;
  localparam int STAT_AVAIL_LSB = 8;
  // reset values
  localparam logic SRC_OD_RST = 1'b1;
  localparam logic SRC_STBY_RST = 1'b0;
  localparam logic [DIV_W-1:0] GEN_DIV_RST = 6'h01;

  typedef struct packed {
    logic standby_run_enable;
    logic on_demand_enable;
  } src_cfg_t;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [SRC_W-1:0] src;
    logic en;
  } gen_cfg_t;

  typedef struct packed {
    logic unmask;
    logic [GEN_W-1:0] gen;
    logic en;
  } ch_cfg_t;

  typedef struct packed {
    logic [CH_W-1:0] sel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } acc_t;

  typedef enum logic [3:0] {
    CH_OFF = 4'h1,
    CH_WAIT = 4'h2,
    CH_ON = 4'h4,
    CH_HOLD = 4'h8
  } ch_state_t;

  typedef enum logic [2:0] {
    SRC_OFF = 3'h1,
    SRC_START = 3'h2,
    SRC_RUN = 3'h4
  } src_state_t;
endpackage

// File: src/bit_sync.sv
// Purpose: two-flop synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [1:0][W-1:0] stage_q;
  logic [1:0][W-1:0] stage_d;

  always_comb begin
    stage_d[0] = async_i;
    stage_d[1] = stage_q[0];
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign sync_o = stage_q[1];
endmodule

// File: src/clk_source_ctrl.sv
// Purpose: run/ready control of one clock source
// Assumes: req_i comes from logic on the same clock
// Notes: run_o and ready_o are flops
`timescale 1ns/1ps
module clk_source_ctrl
  import odcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic req_i,
  input wire logic on_demand_enable_i,
  input wire logic standby_i,
  input wire logic standby_run_enable_i,
  output logic run_o,
  output logic ready_o
);
  typedef struct packed {
    src_state_t state;
    logic [CNT_W-1:0] cnt;
    logic run;
    logic ready;
  } st_t;

  st_t s_q;
  st_t s_d;
  logic allowed;
  logic want;

  // ----------------------------------------------------------------
  // start and stop sequencing
  // ----------------------------------------------------------------
  assign allowed = !standby_i || standby_run_enable_i;
  assign want = allowed && (req_i || !on_demand_enable_i);

  always_comb begin
    s_d = s_q;
    case (s_q.state)
      SRC_OFF: begin
        if (want) begin
          s_d.state = SRC_START;
          s_d.cnt = '0;
        end
      end
      SRC_START: begin
        if (!want) begin
          s_d.state = SRC_OFF;
        end else if (s_q.cnt == CNT_W'(SRC_STARTUP_CYC - 1)) begin
          s_d.state = SRC_RUN;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      SRC_RUN: begin
        if (!want) begin
          s_d.state = SRC_OFF;
        end
      end
      default: begin
        s_d.state = SRC_OFF;
      end
    endcase
    s_d.run = (s_d.state != SRC_OFF);
    s_d.ready = (s_d.state == SRC_RUN);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.state <= SRC_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  assign run_o = s_q.run;
  assign ready_o = s_q.ready;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SRC_IDLE_STOPPED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (on_demand_enable_i && !req_i) |=> !run_o)
    else $error("on-demand source runs without a request");
  AST_SRC_REQ_RUNS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (req_i && allowed) |=> run_o)
    else $error("requested source not running");
  AST_SRC_STAYS_OFF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!run_o && on_demand_enable_i && !req_i) [*2] |=> !run_o && !ready_o)
    else $error("stopped source restarted without a request");
  AST_SRC_FREE_RUN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!on_demand_enable_i && allowed) |=> run_o)
    else $error("source with on-demand cleared is not running");
  AST_SRC_STANDBY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (standby_i && !standby_run_enable_i) |=> !run_o)
    else $error("source runs in standby without standby-run enable");
endmodule

// File: src/on_demand_clock_request.sv
// Purpose: on-demand clock request routing from peripherals to clock sources
// Assumes: peripheral requests and standby arrive asynchronously; source and
//   divided periods are modelled as cycle counts of clk_i
// Notes: registers over a plain strobe port, read data one cycle later
// Functional notes
// - An on-demand source is stopped whenever nobody requests it.
// - Requests pass through the generator to the selected source, which starts or keeps running.
// - With no active request left, the source stops and stays stopped until a new request.
// - A request reaches the source only with channel and generator both enabled.
// - Request to clock available takes at most startup plus two source and two divided periods.
// - Request to clock available for a stopped source takes at least startup plus one source and one divided period.
// - Shutdown after the last request takes one to two source plus divided periods.
// - Clearing a source's on-demand enable keeps it running regardless of requests, except in standby without standby-run enable.
// - In standby requests work only for sources with standby-run enable set.
// - A masked peripheral interface reads as zero and drops writes.
`timescale 1ns/1ps
module on_demand_clock_request
  import odcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [NUM_CH-1:0] periph_req_i,
  input wire logic standby_i,
  output logic [NUM_SRC-1:0] src_run_o,
  output logic [NUM_SRC-1:0] src_ready_o,
  output logic [NUM_CH-1:0] ch_clk_en_o,
  input wire acc_t cpu_acc_i,
  output acc_t per_acc_o,
  input wire logic [DATA_W-1:0] per_rdata_i,
  output logic [DATA_W-1:0] cpu_rdata_o,
  output logic cpu_rvalid_o
);
  typedef struct packed {
    src_cfg_t [NUM_SRC-1:0] src;
    gen_cfg_t [NUM_GEN-1:0] gen;
    ch_cfg_t [NUM_CH-1:0] ch;
    ch_state_t [NUM_CH-1:0] chs;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt;
    logic [NUM_CH-1:0] avail;
    logic [DATA_W-1:0] rdata;
    acc_t acc;
    logic rd1;
    logic rd2;
    logic msk1;
    logic msk2;
    logic [DATA_W-1:0] prdata;
    logic prvalid;
  } st_t;

  localparam int MAX_DLY = SRC_PERIOD_CYC * 64;

  st_t s_q;
  st_t s_d;
  logic [NUM_CH:0] sync_w;
  logic [NUM_CH-1:0] req_sync_w;
  logic standby_w;
  logic [NUM_CH-1:0][GEN_W-1:0] gsel_w;
  logic [NUM_CH-1:0][SRC_W-1:0] ssel_w;
  logic [NUM_CH-1:0] path_ok_w;
  logic [NUM_CH-1:0] eff_w;
  logic [NUM_CH-1:0] rdy_w;
  logic [NUM_CH-1:0][CNT_W-1:0] dly_w;
  logic [NUM_SRC-1:0] src_req;
  logic [NUM_SRC-1:0] src_run_w;
  logic [NUM_SRC-1:0] src_ready_w;
  logic cpu_masked;

  // source period plus one divided period, divider zero taken as one
  function automatic logic [CNT_W-1:0] calc_delay(input logic [DIV_W-1:0] div);
    logic [CNT_W-1:0] d;
    d = (div == '0) ? CNT_W'(1) : CNT_W'(div);
    return CNT_W'(SRC_PERIOD_CYC) * (d + CNT_W'(1));
  endfunction

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [ADDR_W-1:0] base, input int i);
    return base + ADDR_W'(REG_STRIDE * i);
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  bit_sync #(.W(NUM_CH + 1)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({standby_i, periph_req_i}),
    .sync_o(sync_w)
  );
  assign req_sync_w = sync_w[NUM_CH-1:0];
  assign standby_w = sync_w[NUM_CH];

  // ----------------------------------------------------------------
  // per-channel routing and checks
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign gsel_w[c] = s_q.ch[c].gen;
    assign ssel_w[c] = s_q.gen[gsel_w[c]].src;
    assign path_ok_w[c] = s_q.ch[c].en & s_q.gen[gsel_w[c]].en;
    assign eff_w[c] = req_sync_w[c] & path_ok_w[c];
    assign rdy_w[c] = src_ready_w[ssel_w[c]];
    assign dly_w[c] = calc_delay(s_q.gen[gsel_w[c]].div);

    AST_PATH_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.chs[c] == CH_OFF && !path_ok_w[c]) |=> s_q.chs[c] == CH_OFF)
      else $error("request passed a disabled channel or generator");
    AST_START_MIN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.chs[c] == CH_OFF ##1 s_q.chs[c] == CH_WAIT) |-> !s_q.avail[c] [*2])
      else $error("clock available too early after request");
    AST_START_MAX: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.chs[c] == CH_WAIT) |-> s_q.cnt[c] < dly_w[c])
      else $error("divided start wait exceeds one source plus divided period");
    AST_STOP_MIN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.chs[c] == CH_ON && !eff_w[c] && rdy_w[c]) |=> s_q.avail[c] ##1 s_q.avail[c])
      else $error("clock shut down too early");
    AST_STOP_MAX: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(s_q.chs[c] == CH_HOLD) |-> ##[1:MAX_DLY] (s_q.chs[c] != CH_HOLD))
      else $error("clock shut down too late");
  end

  // ----------------------------------------------------------------
  // source request merge and sources
  // ----------------------------------------------------------------
  always_comb begin
    src_req = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (s_q.chs[c] != CH_OFF && ssel_w[c] == SRC_W'(s)) begin
          src_req[s] = 1'b1;
        end
      end
    end
  end

  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    clk_source_ctrl u_src (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .req_i(src_req[s]),
      .on_demand_enable_i(s_q.src[s].on_demand_enable),
      .standby_i(standby_w),
      .standby_run_enable_i(s_q.src[s].standby_run_enable),
      .run_o(src_run_w[s]),
      .ready_o(src_ready_w[s])
    );

    AST_SRC_OR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (src_req[s] && !standby_w) |=> src_run_w[s])
      else $error("source not started for a merged request");
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // register writes
    for (int i = 0; i < NUM_SRC; i++) begin
      if (reg_we_i && reg_addr_i == reg_addr(SRC_CFG_BASE, i)) begin
        s_d.src[i].on_demand_enable = reg_wdata_i[SRC_OD_BIT];
        s_d.src[i].standby_run_enable = reg_wdata_i[SRC_STBY_BIT];
      end
    end
    for (int i = 0; i < NUM_GEN; i++) begin
      if (reg_we_i && reg_addr_i == reg_addr(GEN_CFG_BASE, i)) begin
        s_d.gen[i].en = reg_wdata_i[GEN_EN_BIT];
        s_d.gen[i].src = reg_wdata_i[GEN_SRC_LSB +: SRC_W];
        s_d.gen[i].div = reg_wdata_i[GEN_DIV_LSB +: DIV_W];
      end
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (reg_we_i && reg_addr_i == reg_addr(CH_CFG_BASE, i)) begin
        s_d.ch[i].en = reg_wdata_i[CH_EN_BIT];
        s_d.ch[i].gen = reg_wdata_i[CH_GEN_LSB +: GEN_W];
        s_d.ch[i].unmask = reg_wdata_i[CH_UNMASK_BIT];
      end
    end
    // register reads, unmapped addresses read zero
    s_d.rdata = '0;
    if (reg_re_i) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (reg_addr_i == reg_addr(SRC_CFG_BASE, i)) begin
          s_d.rdata[SRC_OD_BIT] = s_q.src[i].on_demand_enable;
          s_d.rdata[SRC_STBY_BIT] = s_q.src[i].standby_run_enable;
        end
      end
      for (int i = 0; i < NUM_GEN; i++) begin
        if (reg_addr_i == reg_addr(GEN_CFG_BASE, i)) begin
          s_d.rdata[GEN_EN_BIT] = s_q.gen[i].en;
          s_d.rdata[GEN_SRC_LSB +: SRC_W] = s_q.gen[i].src;
          s_d.rdata[GEN_DIV_LSB +: DIV_W] = s_q.gen[i].div;
        end
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr_i == reg_addr(CH_CFG_BASE, i)) begin
          s_d.rdata[CH_EN_BIT] = s_q.ch[i].en;
          s_d.rdata[CH_GEN_LSB +: GEN_W] = s_q.ch[i].gen;
          s_d.rdata[CH_UNMASK_BIT] = s_q.ch[i].unmask;
        end
      end
      if (reg_addr_i == STATUS_ADDR) begin
        s_d.rdata[STAT_RUN_LSB +: NUM_SRC] = src_run_w;
        s_d.rdata[STAT_RDY_LSB +: NUM_SRC] = src_ready_w;
        s_d.rdata[STAT_AVAIL_LSB +: NUM_CH] = s_q.avail;
      end
    end
    // channel request state
    for (int c = 0; c < NUM_CH; c++) begin
      case (s_q.chs[c])
        CH_OFF: begin
          if (eff_w[c]) begin
            s_d.chs[c] = CH_WAIT;
            s_d.cnt[c] = '0;
          end
        end
        CH_WAIT: begin
          if (!eff_w[c]) begin
            s_d.chs[c] = CH_OFF;
          end else if (rdy_w[c]) begin
            if (s_q.cnt[c] == dly_w[c] - CNT_W'(1)) begin
              s_d.chs[c] = CH_ON;
              s_d.avail[c] = 1'b1;
            end else begin
              s_d.cnt[c] = s_q.cnt[c] + CNT_W'(1);
            end
          end
        end
        CH_ON: begin
          if (!rdy_w[c]) begin
            s_d.chs[c] = CH_WAIT;
            s_d.avail[c] = 1'b0;
            s_d.cnt[c] = '0;
          end else if (!eff_w[c]) begin
            s_d.chs[c] = CH_HOLD;
            s_d.cnt[c] = '0;
          end
        end
        CH_HOLD: begin
          if (!rdy_w[c] || s_q.cnt[c] == dly_w[c] - CNT_W'(1)) begin
            s_d.chs[c] = CH_OFF;
            s_d.avail[c] = 1'b0;
          end else if (eff_w[c]) begin
            s_d.chs[c] = CH_ON;
          end else begin
            s_d.cnt[c] = s_q.cnt[c] + CNT_W'(1);
          end
        end
        default: begin
          s_d.chs[c] = CH_OFF;
          s_d.avail[c] = 1'b0;
        end
      endcase
    end
    // peripheral interface gate
    s_d.acc = cpu_acc_i;
    s_d.acc.we = cpu_acc_i.we && !cpu_masked;
    s_d.acc.re = cpu_acc_i.re && !cpu_masked;
    s_d.rd1 = cpu_acc_i.re;
    s_d.msk1 = cpu_masked;
    s_d.rd2 = s_q.rd1;
    s_d.msk2 = s_q.msk1;
    s_d.prvalid = s_q.rd2;
    s_d.prdata = (s_q.rd2 && !s_q.msk2) ? per_rdata_i : '0;
  end

  assign cpu_masked = !s_q.ch[cpu_acc_i.sel].unmask;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      for (int i = 0; i < NUM_SRC; i++) begin
        s_q.src[i].on_demand_enable <= SRC_OD_RST;
        s_q.src[i].standby_run_enable <= SRC_STBY_RST;
      end
      for (int i = 0; i < NUM_GEN; i++) begin
        s_q.gen[i].div <= GEN_DIV_RST;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        s_q.chs[i] <= CH_OFF;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = s_q.rdata;
  assign src_run_o = src_run_w;
  assign src_ready_o = src_ready_w;
  assign ch_clk_en_o = s_q.avail;
  assign per_acc_o = s_q.acc;
  assign cpu_rdata_o = s_q.prdata;
  assign cpu_rvalid_o = s_q.prvalid;

  AST_MASK_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cpu_acc_i.we && cpu_masked) |=> !per_acc_o.we)
    else $error("write to masked peripheral passed");
  AST_MASK_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cpu_acc_i.re && cpu_masked) |-> ##3 (cpu_rvalid_o && cpu_rdata_o == '0))
    else $error("read of masked peripheral not zero");
endmodule

// File: tb/on_demand_clock_request_tb.sv
// Purpose: self-checking bench for the on-demand clock request block
// Assumes: source timing as package cycle counts, sync slack of 4 cycles
// Notes: every scenario is its own task and judges its own results
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module on_demand_clock_request_tb;
  import odcr_pkg::*;
  localparam int P = SRC_PERIOD_CYC;
  localparam int S = SRC_STARTUP_CYC;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [NUM_CH-1:0] want = '0;
  logic [NUM_CH-1:0] periph_req;
  logic standby_i = 1'b0;
  logic [NUM_SRC-1:0] src_run_o;
  logic [NUM_SRC-1:0] src_ready_o;
  logic [NUM_CH-1:0] ch_clk_en_o;
  acc_t cpu_acc_i = '0;
  acc_t per_acc_o;
  logic [DATA_W-1:0] per_rdata_i;
  logic [DATA_W-1:0] cpu_rdata_o;
  logic cpu_rvalid_o;
  int miscompares = 0;
  int total_checks = 0;

  on_demand_clock_request on_demand_clock_request_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .periph_req_i(periph_req), .standby_i(standby_i),
    .src_run_o(src_run_o), .src_ready_o(src_ready_o), .ch_clk_en_o(ch_clk_en_o),
    .cpu_acc_i(cpu_acc_i), .per_acc_o(per_acc_o), .per_rdata_i(per_rdata_i),
    .cpu_rdata_o(cpu_rdata_o), .cpu_rvalid_o(cpu_rvalid_o));

  periph_model periph_model_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .want_i(want), .per_acc_i(per_acc_o),
    .periph_req_o(periph_req), .per_rdata_o(per_rdata_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // bus and wait helpers
  // ----------------------------------------
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e)
  endtask

  // kind 1 watches a source run bit, kind 0 a channel clock enable
  task automatic wait_sig(input int kind, input int idx, input logic v, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
      s = (kind == 1) ? src_run_o[idx] : ch_clk_en_o[idx];
    end while (s !== v && n < 300);
  endtask

  task automatic cpu_go(input logic [CH_W-1:0] ch, input logic we, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    cpu_acc_i <= '{sel: ch, addr: 8'h04, wdata: d, we: we, re: ~we};
    @(posedge clk_i);
    cpu_acc_i <= '0;
    #1;
  endtask

  task automatic cpu_rd(input logic [CH_W-1:0] ch, input logic [DATA_W-1:0] e, input logic f);
    cpu_go(ch, 1'b0, '0);
    `CHK(per_acc_o.re, f)
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(cpu_rvalid_o, 1'b1)
    `CHK(cpu_rdata_o, e)
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK({src_run_o, src_ready_o, ch_clk_en_o}, 8'h00)
    chk_reg(8'h00, 32'h0000_0001);
    chk_reg(8'h10, 32'h0000_0100);
    chk_reg(8'h2c, 32'h0000_0000);
    reg_wr(8'h40, 32'hffff_ffff);
    chk_reg(8'h40, 32'h0000_0000);
  endtask

  task automatic t_gate();
    want <= 4'h1;
    repeat (20) @(posedge clk_i);
    `CHK(src_run_o, 2'h0)
    reg_wr(8'h20, 32'h0000_0001);
    repeat (20) @(posedge clk_i);
    `CHK(src_run_o, 2'h0)
    reg_wr(8'h20, 32'h0000_0000);
    reg_wr(8'h10, 32'h0000_0101);
    repeat (20) @(posedge clk_i);
    `CHK(src_run_o, 2'h0)
    want <= 4'h0;
  endtask

  task automatic t_cycle(input int ch, input int g, input int src, input int dv);
    int n;
    int d;
    // divider zero runs as divide by one
    d = P * ((dv == 0) ? 1 : dv);
    reg_wr(8'h10 + 8'(4 * g), 32'(1 + 2 * src + (dv << 8)));
    reg_wr(8'h20 + 8'(4 * ch), 32'(1 + 2 * g));
    want[ch] <= 1'b1;
    wait_sig(0, ch, 1'b1, n);
    `CHK(n >= S + P + d, 1'b1)
    `CHK(n <= S + 2 * P + 2 * d + 4, 1'b1)
    `CHK(src_run_o, 2'(1 << src))
    `CHK(src_ready_o, 2'(1 << src))
    chk_reg(8'h30, 32'((1 << (8 + ch)) + (1 << (4 + src)) + (1 << src)));
    want[ch] <= 1'b0;
    wait_sig(0, ch, 1'b0, n);
    `CHK(n >= P + d && n <= 2 * P + 2 * d + 4, 1'b1)
    wait_sig(1, src, 1'b0, n);
    repeat (50) @(posedge clk_i);
    `CHK(src_run_o, 2'h0)
  endtask

  task automatic t_share();
    int n;
    reg_wr(8'h2c, 32'h0000_0001);
    want <= 4'h9;
    wait_sig(0, 3, 1'b1, n);
    want <= 4'h8;
    repeat (60) @(posedge clk_i);
    `CHK({src_run_o[0], ch_clk_en_o}, 5'h18)
    want <= 4'h0;
    wait_sig(1, 0, 1'b0, n);
    `CHK(src_run_o, 2'h0)
  endtask

  task automatic t_nodemand();
    int n;
    reg_wr(8'h14, 32'h0000_0103);
    reg_wr(8'h04, 32'h0000_0000);
    repeat (S + 10) @(posedge clk_i);
    `CHK(src_run_o, 2'h2)
    want[1] <= 1'b1;
    wait_sig(0, 1, 1'b1, n);
    `CHK(n < S, 1'b1)
    want[1] <= 1'b0;
    wait_sig(0, 1, 1'b0, n);
    repeat (40) @(posedge clk_i);
    `CHK(src_run_o, 2'h2)
  endtask

  task automatic t_standby();
    standby_i <= 1'b1;
    want <= 4'h1;
    repeat (6) @(posedge clk_i);
    `CHK(src_run_o, 2'h0)
    reg_wr(8'h00, 32'h0000_0003);
    reg_wr(8'h04, 32'h0000_0002);
    repeat (6) @(posedge clk_i);
    `CHK(src_run_o, 2'h3)
    standby_i <= 1'b0;
    want <= 4'h0;
    reg_wr(8'h04, 32'h0000_0001);
    reg_wr(8'h00, 32'h0000_0001);
  endtask

  task automatic t_mask();
    cpu_go(2'h2, 1'b1, 32'h0000_005a);
    `CHK(per_acc_o.we, 1'b0)
    cpu_rd(2'h2, 32'h0000_0000, 1'b0);
    reg_wr(8'h28, 32'h0000_0100);
    cpu_rd(2'h2, 32'h3c3c_3c3c, 1'b1);
    cpu_go(2'h2, 1'b1, 32'h0000_00a5);
    `CHK({per_acc_o.we, per_acc_o.wdata}, {1'b1, 32'h0000_00a5})
    `CHK({per_acc_o.sel, per_acc_o.addr}, {2'h2, 8'h04})
    cpu_rd(2'h2, 32'h0000_00a5, 1'b1);
  endtask

  // ----------------------------------------
  // verdict and main sequence
  // ----------------------------------------
  task automatic close_out();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    t_reset();
    t_gate();
    t_cycle(0, 0, 0, 1);
    t_cycle(1, 1, 1, 3);
    t_cycle(2, 2, 0, 0);
    t_share();
    t_nodemand();
    t_standby();
    t_mask();
    close_out();
  end
endmodule

// File: tb/periph_model.sv
// Purpose: peripheral side model: clock request levels and register interface
// Assumes: forwarded read data is due in the cycle after the forwarded read
// Notes: read data line toggles whenever no read is being answered
`timescale 1ns/1ps
module periph_model
  import odcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [NUM_CH-1:0] want_i,
  input wire acc_t per_acc_i,
  output logic [NUM_CH-1:0] periph_req_o,
  output logic [DATA_W-1:0] per_rdata_o
);
  logic [DATA_W-1:0] mem_q [NUM_CH];

  // request levels straight from each peripheral
  assign periph_req_o = want_i;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mem_q[i] <= 32'h3c3c_3c3c;
      end
      per_rdata_o <= '0;
    end else begin
      if (per_acc_i.we) begin
        mem_q[per_acc_i.sel] <= per_acc_i.wdata;
      end
      // valid only one cycle, never holds the last value
      if (per_acc_i.re) begin
        per_rdata_o <= mem_q[per_acc_i.sel];
      end else begin
        per_rdata_o <= ~per_rdata_o;
      end
    end
  end
endmodule
